// *** hw/tsp_regs.v ***
// Purpose: Timestamp policy registers and the decisions they steer
// Assumes: Register port is a word-addressed strobe interface from the
//          serial management front end; message type is a 3-bit field
// Notes: Decisions are registered, one cycle after a message strobe
//
// Operation
// [R01] First divider of timestamper 1 input is 16 bits; 0 or 1 bypasses.
// [R02] A second cascaded divider follows, ratio from a separate 3-bit field.
// [R03] FIFO type enables act only when both stampers take start-of-packet.
// [R04] Egress stamper source zero selects the egress start-of-packet event.
// [R05] Ingress stamper source zero selects the ingress start-of-packet event.
// [R06] Bits 8 to 15 let egress types 0 to 7 reach the egress FIFO.
// [R07] Bits 0 to 7 let ingress types 0 to 7 reach the ingress FIFO.
// [R08] Types: 0 Sync, 1 Delay_Req, 2 Pdelay_Req, 3 Pdelay_Resp, 4-7 reserved.
// [R09] Bit 12 enables one-step residence time correction of forwarded events.
// [R10] Bit 15 extends correction to peer delay types; needs bit 12.
// [R11] Bit 14 zeros the insertion byte ranges in egress messages.
// [R12] Bit 13 enables circuit emulation insertion, only in that timing mode.
// [R13] Bits 8 to 11 enable one-step insertion for egress types 0 to 3.
// [R14] Bits 0 to 7 enable ingress timestamp writing for types 0 to 7.
// [R15] One-step enable for a type overrides residence correction for it.
// [R16] All fields reset to zero.
`default_nettype none
`timescale 1ns/10ps
`include "tsp_consts.vh"
module tsp_regs (
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [4:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire [2:0] second_input_divider_i,
    input wire [1:0] egress_stamper_source_i,
    input wire [1:0] ingress_stamper_source_i,
    input wire circuit_emulation_mode_i,
    input wire ts1_event_pin_i,
    output reg ts1_event_o,
    input wire egress_sop_i,
    input wire ingress_sop_i,
    output reg egress_stamper_sop_o,
    output reg ingress_stamper_sop_o,
    input wire egress_msg_i,
    input wire [2:0] egress_type_i,
    input wire ingress_msg_i,
    input wire [2:0] ingress_type_i,
    output reg egress_fifo_push_o,
    output reg ingress_fifo_push_o,
    output reg egress_one_step_o,
    output reg egress_residence_fix_o,
    output reg egress_clear_bytes_o,
    output reg ingress_write_stamp_o,
    output reg ingress_ce_insert_o,
    output reg [15:0] first_input_divider_o,
    output reg [15:0] fifo_type_enable_o,
    output reg [15:0] insertion_enable_o
);
    reg [15:0] div1_q;
    reg [15:0] fifo_en_q;
    reg [15:0] ins_en_q;
    reg [2:0] pin_sync_q;
    reg pin_lvl_q;
    reg pin_ev;
    wire div_ev;
    wire sop_path;

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function sel_bit;
        input [7:0] vec;
        input [2:0] idx;
        begin
            sel_bit = vec[idx];
        end
    endfunction

    // Peer delay types are 2 and 3, the only ones behind the extension bit
    function is_peer;
        input [2:0] t;
        begin
            is_peer = (t == `TSP_MT_PREQ) || (t == `TSP_MT_PRESP); // see [R08]
        end
    endfunction

    // ------------------------------------------------
    // Register port
    // ------------------------------------------------
    always @(posedge mclk_i) begin
        if (srst_i) begin
            div1_q <= `TSP_RST_VAL; // see [R16]
            fifo_en_q <= `TSP_RST_VAL;
            ins_en_q <= `TSP_RST_VAL;
            reg_rdata_o <= `TSP_ZERO16;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `TSP_ADDR_DIV1: div1_q <= reg_wdata_i;
                    `TSP_ADDR_FIFO: fifo_en_q <= reg_wdata_i;
                    `TSP_ADDR_INS: ins_en_q <= reg_wdata_i;
                    default: ;
                endcase
            end
            if (reg_rd_i) begin
                // Unmapped addresses read as zero
                case (reg_addr_i)
                    `TSP_ADDR_DIV1: reg_rdata_o <= div1_q;
                    `TSP_ADDR_FIFO: reg_rdata_o <= fifo_en_q;
                    `TSP_ADDR_INS: reg_rdata_o <= ins_en_q;
                    default: reg_rdata_o <= `TSP_ZERO16;
                endcase
            end
        end
    end

    // ------------------------------------------------
    // Timestamper 1 input path
    // ------------------------------------------------
    always @(posedge mclk_i) begin
        if (srst_i) begin
            pin_sync_q <= 3'h0;
            pin_lvl_q <= 1'b0;
        end else if (ce_i) begin
            pin_sync_q <= {pin_sync_q[1:0], ts1_event_pin_i};
            // Accept a level only when the last two stages agree
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end

    always @* begin
        pin_ev = ce_i & (pin_sync_q[1] == pin_sync_q[2]) & pin_sync_q[2] & ~pin_lvl_q;
    end

    tsp_div u_div (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .ev_i(pin_ev),
        .ratio1_i(div1_q), // see [R01]
        .sel2_i(second_input_divider_i), // see [R02]
        .ev_o(div_ev)
    );

    // FIFO enables are meaningless unless both stampers watch packets
    assign sop_path = (egress_stamper_source_i == `TSP_SRC_SOP) &&
                      (ingress_stamper_source_i == `TSP_SRC_SOP); // see [R03]

    // ------------------------------------------------
    // Decisions
    // ------------------------------------------------
    always @(posedge mclk_i) begin
        if (srst_i) begin
            ts1_event_o <= 1'b0;
            egress_stamper_sop_o <= 1'b0;
            ingress_stamper_sop_o <= 1'b0;
            egress_fifo_push_o <= 1'b0;
            ingress_fifo_push_o <= 1'b0;
            egress_one_step_o <= 1'b0;
            egress_residence_fix_o <= 1'b0;
            egress_clear_bytes_o <= 1'b0;
            ingress_write_stamp_o <= 1'b0;
            ingress_ce_insert_o <= 1'b0;
            first_input_divider_o <= `TSP_ZERO16;
            fifo_type_enable_o <= `TSP_ZERO16;
            insertion_enable_o <= `TSP_ZERO16;
        end else if (ce_i) begin
            ts1_event_o <= div_ev;
            egress_stamper_sop_o <= egress_sop_i &&
                (egress_stamper_source_i == `TSP_SRC_SOP); // see [R04]
            ingress_stamper_sop_o <= ingress_sop_i &&
                (ingress_stamper_source_i == `TSP_SRC_SOP); // see [R05]
            egress_fifo_push_o <= egress_msg_i && sop_path &&
                sel_bit(fifo_en_q[`TSP_EG_HI:`TSP_EG_LO], egress_type_i); // see [R06]
            ingress_fifo_push_o <= ingress_msg_i && sop_path &&
                sel_bit(fifo_en_q[`TSP_IN_HI:`TSP_IN_LO], ingress_type_i); // see [R07]
            // Only types 0 to 3 have a one-step bit
            egress_one_step_o <= egress_msg_i && !egress_type_i[`TSP_MT_HI_BIT] &&
                sel_bit({4'h0, ins_en_q[`TSP_BIT_OS_HI:`TSP_BIT_OS_LO]}, egress_type_i); // see [R13]
            egress_residence_fix_o <= egress_msg_i && ins_en_q[`TSP_BIT_TC] && // see [R09]
                (!is_peer(egress_type_i) || ins_en_q[`TSP_BIT_PD]) && // see [R10]
                !(!egress_type_i[`TSP_MT_HI_BIT] &&
                  sel_bit({4'h0, ins_en_q[`TSP_BIT_OS_HI:`TSP_BIT_OS_LO]}, egress_type_i)); // see [R15]
            egress_clear_bytes_o <= egress_msg_i && ins_en_q[`TSP_BIT_CLR]; // see [R11]
            ingress_write_stamp_o <= ingress_msg_i &&
                sel_bit(ins_en_q[`TSP_IN_HI:`TSP_IN_LO], ingress_type_i); // see [R14]
            ingress_ce_insert_o <= ingress_msg_i && circuit_emulation_mode_i &&
                ins_en_q[`TSP_BIT_TOP]; // see [R12]
            first_input_divider_o <= div1_q;
            fifo_type_enable_o <= fifo_en_q;
            insertion_enable_o <= ins_en_q;
        end
    end
endmodule // tsp_regs
`default_nettype wire

// *** hw/tsp_consts.vh ***
// Purpose: Constants for the timestamp policy register bank
// Assumes: 16-bit registers at word addresses, one system clock
// Notes: Included by both design files
`ifndef TSP_CONSTS_VH
`define TSP_CONSTS_VH
`define TSP_ADDR_W 5
`define TSP_DATA_W 16
`define TSP_ADDR_DIV1 5'h14
`define TSP_ADDR_FIFO 5'h15
`define TSP_ADDR_INS 5'h16
`define TSP_RST_VAL 16'h0000
`define TSP_ZERO16 16'h0000
`define TSP_ONE16 16'h0001
`define TSP_EG_LO 8
`define TSP_EG_HI 15
`define TSP_IN_LO 0
`define TSP_IN_HI 7
`define TSP_BIT_PD 15
`define TSP_BIT_CLR 14
`define TSP_BIT_TOP 13
`define TSP_BIT_TC 12
`define TSP_BIT_OS_LO 8
`define TSP_BIT_OS_HI 11
`define TSP_SRC_SOP 2'h0
`define TSP_MT_SYNC 3'h0
`define TSP_MT_DREQ 3'h1
`define TSP_MT_PREQ 3'h2
`define TSP_MT_PRESP 3'h3
`define TSP_MT_HI_BIT 2
`define TSP_DIV2_NONE 3'h0
`define TSP_DIV2_10 3'h1
`define TSP_DIV2_1000A 3'h2
`define TSP_DIV2_1000B 3'h3
`define TSP_DIV2_2 3'h4
`define TSP_DIV2_80 3'h5
`define TSP_DIV2_800 3'h6
`define TSP_DIV2_8000 3'h7
`define TSP_R10 13'h000a
`define TSP_R1000 13'h03e8
`define TSP_R2 13'h0002
`define TSP_R80 13'h0050
`define TSP_R800 13'h0320
`define TSP_R8000 13'h1f40
`define TSP_R1 13'h0001
`define TSP_ZERO13 13'h0000
`endif

// *** hw/tsp_div.v ***
// Purpose: Cascaded two-stage event divider ahead of timestamper 1
// Assumes: Input is already synchronised; one pulse per event
// Notes: Outputs a one-cycle pulse per divided event
`default_nettype none
`timescale 1ns/10ps
`include "tsp_consts.vh"
module tsp_div (
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    input wire ev_i,
    input wire [15:0] ratio1_i,
    input wire [2:0] sel2_i,
    output reg ev_o
);
    reg [15:0] cnt1_q;
    reg [12:0] cnt2_q;
    reg mid_q;
    reg [12:0] ratio2;

    // --------------------------------
    // Second stage ratio decode
    // --------------------------------
    always @* begin
        case (sel2_i)
            `TSP_DIV2_NONE: ratio2 = `TSP_R1;
            `TSP_DIV2_10: ratio2 = `TSP_R10;
            `TSP_DIV2_1000A: ratio2 = `TSP_R1000;
            `TSP_DIV2_1000B: ratio2 = `TSP_R1000;
            `TSP_DIV2_2: ratio2 = `TSP_R2;
            `TSP_DIV2_80: ratio2 = `TSP_R80;
            `TSP_DIV2_800: ratio2 = `TSP_R800;
            `TSP_DIV2_8000: ratio2 = `TSP_R8000;
            default: ratio2 = `TSP_R1;
        endcase
    end

    // --------------------------------
    // Counters
    // --------------------------------
    always @(posedge mclk_i) begin
        if (srst_i) begin
            cnt1_q <= `TSP_ZERO16;
            cnt2_q <= `TSP_ZERO13;
            mid_q <= 1'b0;
            ev_o <= 1'b0;
        end else if (ce_i) begin
            mid_q <= 1'b0;
            ev_o <= 1'b0;
            if (ev_i) begin
                // Zero and one both mean pass-through
                if (ratio1_i <= `TSP_ONE16 || cnt1_q >= ratio1_i - `TSP_ONE16) begin // see [R01]
                    cnt1_q <= `TSP_ZERO16;
                    mid_q <= 1'b1;
                end else begin
                    cnt1_q <= cnt1_q + `TSP_ONE16;
                end
            end
            if (mid_q) begin
                // A shrunk ratio fires at once rather than wrapping
                if (cnt2_q >= ratio2 - `TSP_R1) begin // see [R02]
                    cnt2_q <= `TSP_ZERO13;
                    ev_o <= 1'b1;
                end else begin
                    cnt2_q <= cnt2_q + `TSP_R1;
                end
            end
        end
    end
endmodule // tsp_div
`default_nettype wire

// *** tb/tsp_regs_checker.sv ***
// Purpose: Port checks for tsp_regs
// Assumes: One clock, synchronous reset
// Notes: Bound into every tsp_regs
`timescale 1ns/10ps
`default_nettype none
module tsp_regs_checker (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire logic [1:0] egress_stamper_source_i,
    input wire logic [1:0] ingress_stamper_source_i,
    input wire logic circuit_emulation_mode_i,
    input wire logic egress_msg_i,
    input wire logic ingress_msg_i,
    input wire logic [2:0] egress_type_i,
    input wire logic egress_sop_i,
    input wire logic egress_stamper_sop_o,
    input wire logic egress_fifo_push_o,
    input wire logic ingress_fifo_push_o,
    input wire logic egress_one_step_o,
    input wire logic egress_residence_fix_o,
    input wire logic ingress_ce_insert_o,
    input wire logic [15:0] insertion_enable_o
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wire logic s0 = egress_stamper_source_i == 2'h0 && ingress_stamper_source_i == 2'h0;
    property p_rv; ce_i && reg_rd_i |=> reg_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read unanswered");
    property p_rv_src; reg_rvalid_o |-> $past(ce_i && reg_rd_i); endproperty
    a_rv_src: assert property (p_rv_src) else $error("stray answer");
    property p_ep; egress_fifo_push_o |-> $past(ce_i && egress_msg_i && s0); endproperty
    a_ep: assert property (p_ep) else $error("egress push bad");
    property p_ip; ingress_fifo_push_o |-> $past(ingress_msg_i && s0); endproperty
    a_ip: assert property (p_ip) else $error("ingress push bad");
    property p_sop; ce_i && egress_sop_i && egress_stamper_source_i == 2'h0 |=> egress_stamper_sop_o; endproperty
    a_sop: assert property (p_sop) else $error("sop lost");
    property p_os; egress_one_step_o |-> $past(egress_msg_i && !egress_type_i[2]); endproperty
    a_os: assert property (p_os) else $error("one step bad");
    property p_fix; egress_residence_fix_o |-> !egress_one_step_o; endproperty
    a_fix: assert property (p_fix) else $error("fix with one step");
    property p_cei; ingress_ce_insert_o |-> $past(ingress_msg_i && circuit_emulation_mode_i); endproperty
    a_cei: assert property (p_cei) else $error("insert outside mode");
    property p_rst;
        disable iff (1'b0) srst_i |=> !egress_fifo_push_o && !reg_rvalid_o && insertion_enable_o == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state bad");
    c_push: cover property (egress_fifo_push_o && ingress_fifo_push_o);
    c_fix: cover property (egress_residence_fix_o);
    c_cei: cover property (ingress_ce_insert_o);
endmodule // tsp_regs_checker
bind tsp_regs tsp_regs_checker u_chk (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .reg_rd_i(reg_rd_i),
    .reg_rvalid_o(reg_rvalid_o),
    .egress_stamper_source_i(egress_stamper_source_i),
    .ingress_stamper_source_i(ingress_stamper_source_i),
    .circuit_emulation_mode_i(circuit_emulation_mode_i),
    .egress_msg_i(egress_msg_i),
    .ingress_msg_i(ingress_msg_i),
    .egress_type_i(egress_type_i),
    .egress_sop_i(egress_sop_i),
    .egress_stamper_sop_o(egress_stamper_sop_o),
    .egress_fifo_push_o(egress_fifo_push_o),
    .ingress_fifo_push_o(ingress_fifo_push_o),
    .egress_one_step_o(egress_one_step_o),
    .egress_residence_fix_o(egress_residence_fix_o),
    .ingress_ce_insert_o(ingress_ce_insert_o),
    .insertion_enable_o(insertion_enable_o)
);
`default_nettype wire

// *** tb/tsp_host.sv ***
// Purpose: Management host model on the strobe port
// Assumes: One access per call
// Notes: Released strobes go low; released address and data lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module tsp_host (
    input wire logic mclk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [4:0] addr_o,
    output logic [15:0] wdata_o
);
    // ------
    // Access
    // ------
    initial begin
        {wr_o, rd_o, addr_o, wdata_o} = '0;
    end
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
        @(negedge mclk_i);
        {wr_o, rd_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
    endtask
endmodule // tsp_host
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for tsp_regs
// Assumes: Host model drives the register port
// Notes: Expected results queue up; a monitor compares
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // -----
    // Bench
    // -----
    logic mclk_i = 0, srst_i = 1, ce_i = 1, reg_wr_i, reg_rd_i, reg_rvalid_o, ts1_event_pin_i = 0, hit;
    logic [4:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, first_input_divider_o, fifo_type_enable_o, insertion_enable_o;
    logic [2:0] second_input_divider_i = 0, egress_type_i = 0, ingress_type_i = 0;
    logic [1:0] egress_stamper_source_i = 0, ingress_stamper_source_i = 0;
    logic circuit_emulation_mode_i = 0, egress_sop_i = 0, ingress_sop_i = 0, egress_msg_i = 0, ingress_msg_i = 0;
    logic ts1_event_o, egress_stamper_sop_o, ingress_stamper_sop_o, egress_fifo_push_o, ingress_fifo_push_o;
    logic egress_one_step_o, egress_residence_fix_o, egress_clear_bytes_o, ingress_write_stamp_o, ingress_ce_insert_o;
    logic [15:0] m [20:22] = '{default: 16'h0000};
    logic [15:0] rq [$];
    logic [8:0] mq [$];
    logic [31:0] x, xs = 32'h0000_0041;
    int mismatches = 0, samples_checked = 0, evn = 0;
    tsp_regs uut (.*);
    tsp_host host (.mclk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    always #10 mclk_i = ~mclk_i;
    function automatic logic [31:0] rnd;
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction
    function automatic logic [8:0] expv(input logic [2:0] e, input logic [2:0] i);
        logic s, o;
        logic [15:0] f, n;
        f = m[21];
        n = m[22];
        s = egress_stamper_source_i == 0 && ingress_stamper_source_i == 0;
        o = !e[2] && n[8 + e];
        return {egress_stamper_source_i == 0, ingress_stamper_source_i == 0, s && f[8 + e], o,
                n[12] && (e[2:1] != 1 || n[15]) && !o, n[14], s && f[i], n[i], n[13] && circuit_emulation_mode_i};
    endfunction
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t register got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_dec(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t decisions got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t count got %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        if (ce_i && a >= 20 && a <= 22) m[a] = d;
        host.acc(1, a, d);
    endtask
    task automatic rd(input logic [4:0] a);
        rq.push_back(a >= 20 && a <= 22 ? m[a] : 16'h0000);
        host.acc(0, a, 16'h0000);
    endtask
    task automatic msg(input logic [2:0] e, input logic [2:0] i);
        @(negedge mclk_i);
        {egress_msg_i, ingress_msg_i, egress_sop_i, ingress_sop_i, egress_type_i, ingress_type_i} = {4'hf, e, i};
        mq.push_back(expv(e, i));
        @(negedge mclk_i);
        {egress_msg_i, ingress_msg_i, egress_sop_i, ingress_sop_i, egress_type_i, ingress_type_i} = {4'h0, ~e, ~i};
    endtask
    task automatic pulses(input int n, input int want);
        evn = 0;
        repeat (n) begin
            ts1_event_pin_i = 1;
            repeat (5) @(negedge mclk_i);
            ts1_event_pin_i = 0;
            repeat (5) @(negedge mclk_i);
        end
        repeat (10) @(negedge mclk_i);
        chk_cnt(evn[15:0], want[15:0]);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        hit = egress_msg_i;
        #1;
        if (ts1_event_o === 1'b1) evn++;
        if (reg_rvalid_o === 1'b1) chk_rd(reg_rdata_o, rq.size() ? rq.pop_front() : 16'hxxxx);
        if (hit === 1'b1) chk_dec({egress_stamper_sop_o, ingress_stamper_sop_o, egress_fifo_push_o,
            egress_one_step_o, egress_residence_fix_o, egress_clear_bytes_o, ingress_fifo_push_o,
            ingress_write_stamp_o, ingress_ce_insert_o}, mq.pop_front());
    end
    initial begin
        repeat (2) @(negedge mclk_i);
        srst_i = 0;
        for (int a = 20; a < 24; a++) rd(a[4:0]);
        pulses(2, 2);
        wr(20, 16'h0003);
        pulses(6, 2);
        second_input_divider_i = 3'h4;
        wr(20, 16'h0001);
        pulses(4, 2);
        second_input_divider_i = 3'h1;
        pulses(10, 1);
        // Frozen clock must drop this write
        ce_i = 0;
        wr(21, 16'hffff);
        ce_i = 1;
        rd(21);
        chk_rd(fifo_type_enable_o, m[21]);
        for (int k = 0; k < 40; k++) begin
            x = rnd();
            wr(21, x[15:0]);
            wr(22, x[31:16]);
            x = rnd();
            egress_stamper_source_i = x[2] ? x[1:0] : 2'h0;
            ingress_stamper_source_i = x[5] ? x[4:3] : 2'h0;
            circuit_emulation_mode_i = x[6];
            for (int t = 0; t < 8; t++) msg(t[2:0], 3'(7 - t));
            chk_rd(first_input_divider_o, m[20]);
            chk_rd(fifo_type_enable_o, m[21]);
            chk_rd(insertion_enable_o, m[22]);
            rd(x[11:7]);
            rd(21);
            rd(22);
        end
        // Mid-run reset must clear written values
        srst_i = 1;
        repeat (2) @(negedge mclk_i);
        srst_i = 0;
        m = '{default: 16'h0000};
        for (int a = 20; a < 23; a++) rd(a[4:0]);
        chk_rd(insertion_enable_o, 16'h0000);
        chk_rd(first_input_divider_o, 16'h0000);
        repeat (4) @(negedge mclk_i);
        chk_cnt(16'(rq.size() + mq.size()), 16'h0000);
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
